//--- core/wdt_ctrl.sv
// watchdog with write-protected control/status register, apb slave
// assumes an apb master on i_clk; zero other clock domains
//
// Summary of operation
// - bit 7 lock blocks writes to bit 6
// - bit 6 set allows 8-bit counter writes
// - bit 5 lock blocks writes to bit 4
// - bit 4 set allows writes to bits 2,0
// - bits 3 and 1 lock bits 2 and 0
// - bit 2 runs the counter
// - overflow raises internal reset, sets bit 0
// - counter advances once per 8192 clocks
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/100ps
module wdt_ctrl
  import wdt_pkg::*;
#(
  parameter int PRESCALE_CYCLES = PRESCALE_DIV // shorten in simulation
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [17:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic o_irq,
  output logic o_internal_reset
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  ctrl_status_t csr_ff;      // control/status register
  ctrl_status_t nxt_csr;     // its next value
  logic [7:0] counter_ff;    // watchdog counter
  logic [PRESCALE_W-1:0] prescale_ff; // system clock divider
  irq_bits_t irq_status_ff;  // sticky event bits
  irq_bits_t irq_mask_ff;    // enables onto o_irq
  logic [31:0] prdata_ff;    // read data
  logic pready_ff;           // access complete
  logic pslverr_ff;          // unmapped address
  logic irq_ff;              // interrupt level
  logic int_reset_ff;        // internal reset pulse

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic access;      // access phase, before pready
  logic done;        // edge at which the transfer completes
  logic wr_done;     // write takes effect now
  logic hit_csr;     // address decodes
  logic hit_cnt;
  logic hit_ists;
  logic hit_imsk;
  logic mapped;
  logic csr_wr;
  logic cnt_wr;
  logic tick;        // one-cycle count enable
  logic overflow;    // counter wraps this cycle
  logic blocked;     // csr write while bit 7 or bit 5 set or bit 4 clear
  irq_bits_t irq_set;

  assign access = i_psel & i_penable & ~pready_ff;
  assign done = i_psel & i_penable & pready_ff;
  assign wr_done = done & i_pwrite;
  assign hit_csr = (i_paddr == ADDR_CTRL_STATUS);
  assign hit_cnt = (i_paddr == ADDR_COUNTER);
  assign hit_ists = (i_paddr == ADDR_IRQ_STATUS);
  assign hit_imsk = (i_paddr == ADDR_IRQ_MASK);
  assign mapped = hit_csr | hit_cnt | hit_ists | hit_imsk;
  assign csr_wr = wr_done & hit_csr;
  assign cnt_wr = wr_done & hit_cnt & csr_ff.counter_write_enable;

  // ----------------------------------------------------------------
  // apb handshake: one wait state, answer from flops
  // ----------------------------------------------------------------
  // pready rises one cycle into the access phase, read data with it
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      pready_ff <= access;
      pslverr_ff <= access & ~mapped;
      if (access && !i_pwrite) begin
        // read mux; unmapped reads give zero
        if (hit_csr) begin
          prdata_ff <= {24'h0000_00, csr_ff};
        end else if (hit_cnt) begin
          prdata_ff <= {24'h0000_00, counter_ff};
        end else if (hit_ists) begin
          prdata_ff <= {30'h0000_0000, irq_status_ff};
        end else if (hit_imsk) begin
          prdata_ff <= {30'h0000_0000, irq_mask_ff};
        end else begin
          prdata_ff <= 32'h0000_0000;
        end
      end else if (done) begin
        prdata_ff <= 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // control/status write gating
  // ----------------------------------------------------------------
  // gates use the value held before the write, not the new data
  always_comb begin
    nxt_csr = csr_ff;
    if (csr_wr) begin
      // lock bits themselves are always writable
      nxt_csr.lock_counter_write_enable = i_pwdata[7];
      nxt_csr.lock_control_write_enable = i_pwdata[5];
      nxt_csr.lock_watchdog_on = i_pwdata[3];
      nxt_csr.lock_overflow_flag = i_pwdata[1];
      if (!csr_ff.lock_counter_write_enable) begin
        nxt_csr.counter_write_enable = i_pwdata[6];
      end
      if (!csr_ff.lock_control_write_enable) begin
        nxt_csr.control_write_enable = i_pwdata[4];
      end
      if (csr_ff.control_write_enable &&
          !csr_ff.lock_watchdog_on) begin
        nxt_csr.watchdog_on = i_pwdata[2];
      end
      if (csr_ff.control_write_enable &&
          !csr_ff.lock_overflow_flag) begin
        nxt_csr.overflow_reset_flag = i_pwdata[0];
      end
    end
    // overflow wins over a clearing write in the same cycle
    if (overflow) begin
      nxt_csr.overflow_reset_flag = 1'b1;
    end
  end

  // register update
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      csr_ff <= ctrl_status_t'(CTRL_STATUS_RESET);
    end else begin
      csr_ff <= nxt_csr;
    end
  end

  // ----------------------------------------------------------------
  // prescaler and counter
  // ----------------------------------------------------------------
  assign tick = csr_ff.watchdog_on &
      (prescale_ff == PRESCALE_W'(PRESCALE_CYCLES - 1));
  assign overflow = tick & ~cnt_wr &
      (counter_ff == COUNTER_MAX);

  // divider restarts while the watchdog is off
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      prescale_ff <= '0;
    end else if (!csr_ff.watchdog_on || tick) begin
      prescale_ff <= '0;
    end else begin
      prescale_ff <= prescale_ff + PRESCALE_W'(1);
    end
  end

  // a permitted write beats a tick in the same cycle
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      counter_ff <= COUNTER_RESET;
    end else if (cnt_wr) begin
      counter_ff <= i_pwdata[7:0];
    end else if (tick) begin
      counter_ff <= counter_ff + 8'h01;
    end
  end

  // internal reset: one-cycle pulse after the wrap
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      int_reset_ff <= 1'b0;
    end else begin
      int_reset_ff <= overflow;
    end
  end

  // ----------------------------------------------------------------
  // interrupt status, mask and output
  // ----------------------------------------------------------------
  assign blocked = csr_wr & (csr_ff.lock_counter_write_enable |
      csr_ff.lock_control_write_enable |
      ~csr_ff.control_write_enable);
  assign irq_set = '{blocked_write: blocked, overflow: overflow};

  // write one to clear; a new event in the same cycle stays set
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      irq_status_ff <= irq_bits_t'(IRQ_RESET);
    end else if (wr_done && hit_ists) begin
      irq_status_ff <= (irq_status_ff & ~irq_bits_t'(i_pwdata[1:0]))
          | irq_set;
    end else begin
      irq_status_ff <= irq_status_ff | irq_set;
    end
  end

  // mask register
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      irq_mask_ff <= irq_bits_t'(IRQ_RESET);
    end else if (wr_done && hit_imsk) begin
      irq_mask_ff <= irq_bits_t'(i_pwdata[1:0]);
    end
  end

  // level output, one cycle behind the status
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(irq_status_ff & irq_mask_ff);
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_prdata = prdata_ff;
  assign o_pready = pready_ff;
  assign o_pslverr = pslverr_ff;
  assign o_irq = irq_ff;
  assign o_internal_reset = int_reset_ff;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  // locked bit 6 survives a write
  chk_lock_ctr_we: assert property (
    csr_wr && csr_ff.lock_counter_write_enable |=>
      $stable(csr_ff.counter_write_enable))
    else $error("bit 6 changed while locked");

  // counter write only with bit 6 set
  chk_ctr_write_gate: assert property (
    wr_done && hit_cnt && !csr_ff.counter_write_enable && !tick |=>
      $stable(counter_ff))
    else $error("counter written without enable");

  // enabled counter write lands
  chk_ctr_write_land: assert property (
    wr_done && hit_cnt && csr_ff.counter_write_enable |=>
      counter_ff == $past(i_pwdata[7:0]))
    else $error("counter write lost");

  // locked bit 4 survives a write
  chk_lock_ctl_we: assert property (
    csr_wr && csr_ff.lock_control_write_enable |=>
      $stable(csr_ff.control_write_enable))
    else $error("bit 4 changed while locked");

  // bit 2 guarded by bit 4 and its lock
  chk_ctl_gate_on: assert property (
    csr_wr && (!csr_ff.control_write_enable ||
      csr_ff.lock_watchdog_on) |=> $stable(csr_ff.watchdog_on))
    else $error("watchdog_on written through closed gate");

  // bit 0 guarded by bit 4 and its lock
  chk_ctl_gate_flag: assert property (
    csr_wr && !overflow && (!csr_ff.control_write_enable ||
      csr_ff.lock_overflow_flag) |=>
      $stable(csr_ff.overflow_reset_flag))
    else $error("flag written through closed gate");

  // counter idles while off
  chk_count_off: assert property (
    !csr_ff.watchdog_on && !cnt_wr |=> $stable(counter_ff))
    else $error("counter moved while off");

  // wrap sets flag and pulses internal reset
  chk_overflow_flag: assert property (
    tick && !cnt_wr && counter_ff == COUNTER_MAX |=>
      counter_ff == 8'h00 && csr_ff.overflow_reset_flag
      ##0 o_internal_reset ##1 !o_internal_reset)
    else $error("overflow not reported");

  // counter steps only on a divider wrap
  chk_tick_spacing: assert property (
    !cnt_wr && counter_ff != $past(counter_ff) && !$past(cnt_wr) |->
      $past(prescale_ff) == PRESCALE_W'(PRESCALE_CYCLES - 1))
    else $error("counter stepped off the divider");

  // tick adds exactly one
  chk_count_step: assert property (
    tick && !cnt_wr |=> counter_ff == $past(counter_ff) + 8'h01)
    else $error("counter step wrong");

  cov_overflow: cover property (overflow ##1 o_internal_reset);
  cov_locked_write: cover property (csr_wr && blocked);
  cov_irq: cover property (overflow ##2 o_irq);
  cov_ctr_load: cover property (cnt_wr ##[1:1000] tick);

endmodule : wdt_ctrl

//--- core/wdt_pkg.sv
// watchdog package: register map, field layout, reset values, counts
// assumes a 32-bit apb master on the same clock as the watchdog
package wdt_pkg;

  // ----------------------------------------------------------------
  // register indices; each register is one aligned 32-bit word,
  // so its byte address is the index times four
  // ----------------------------------------------------------------
  localparam logic [15:0] IDX_CTRL_STATUS = 16'hffc0;
  localparam logic [15:0] IDX_COUNTER = 16'hffc1;
  localparam logic [15:0] IDX_IRQ_STATUS = 16'hffc2; // block-local slot
  localparam logic [15:0] IDX_IRQ_MASK = 16'hffc3; // block-local slot
  // register byte addresses
  localparam logic [17:0] ADDR_CTRL_STATUS = {IDX_CTRL_STATUS, 2'b00};
  localparam logic [17:0] ADDR_COUNTER = {IDX_COUNTER, 2'b00};
  localparam logic [17:0] ADDR_IRQ_STATUS = {IDX_IRQ_STATUS, 2'b00};
  localparam logic [17:0] ADDR_IRQ_MASK = {IDX_IRQ_MASK, 2'b00};

  // ----------------------------------------------------------------
  // control/status register layout, msb first (bit 7 .. bit 0)
  // ----------------------------------------------------------------
  typedef struct packed {
    logic lock_counter_write_enable; // bit 7
    logic counter_write_enable;      // bit 6
    logic lock_control_write_enable; // bit 5
    logic control_write_enable;      // bit 4
    logic lock_watchdog_on;          // bit 3
    logic watchdog_on;               // bit 2
    logic lock_overflow_flag;        // bit 1
    logic overflow_reset_flag;       // bit 0
  } ctrl_status_t;

  // interrupt status and mask share this layout
  typedef struct packed {
    logic blocked_write; // bit 1: csr write with bit 7 or 5 set or bit 4 clear
    logic overflow;      // bit 0: counter wrapped
  } irq_bits_t;

  // ----------------------------------------------------------------
  // reset values and counts
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_STATUS_RESET = 8'h00;
  localparam logic [7:0] COUNTER_RESET = 8'h00;
  localparam logic [7:0] COUNTER_MAX = 8'hff;
  localparam logic [1:0] IRQ_RESET = 2'h0;
  localparam int PRESCALE_DIV = 8192;  // system clocks per count
  localparam int PRESCALE_W = 13;      // width of the prescaler
  // software load values before flash passes
  localparam logic [7:0] PROGRAM_PASS_COUNT = 8'hfb;
  localparam logic [7:0] ERASE_PASS_COUNT = 8'h00;

endpackage : wdt_pkg

//--- tb/test_watchdog_ctrl_write_protect.sv
// self-checking bench for the write-protected watchdog block
// assumes wdt_pkg and wdt_ctrl are compiled first; one 100 mhz clock
`timescale 1ns/100ps
module test_watchdog_ctrl_write_protect;
  import wdt_pkg::*;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  localparam int PRESC = 8; // shortened prescaler for simulation
  logic i_clk = 1'b0; // system clock
  logic i_reset_n = 1'b0; // async reset, active low
  logic psel = 1'b0; // apb select
  logic penable = 1'b0; // apb enable
  logic pwrite = 1'b0; // apb direction
  logic [17:0] paddr = 18'h0_0000; // apb byte address
  logic [31:0] pwdata = 32'h0000_0000; // apb write data
  logic [31:0] prdata; // read data
  logic pready, pslverr, irq, int_reset; // design answers
  int fail_count = 0; // mismatches seen
  int comparisons = 0; // compares made
  logic [31:0] rdv; // last read data
  logic errv; // last error response
  always #5 i_clk = ~i_clk; // 10 ns period
  wdt_ctrl #(.PRESCALE_CYCLES(PRESC)) uut (.i_clk(i_clk),
    .i_reset_n(i_reset_n), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .o_irq(irq), .o_internal_reset(int_reset));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  // compare, count and report
  task automatic chk(input string name, input logic [31:0] seen,
                     input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [17:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    // wait for the answer however long it takes; the watchdog ends a hang
    do begin
      @(posedge i_clk);
      n++;
    end while (pready !== 1'b1);
    // one wait state: pready is seen at the second edge of the access
    chk("pready_wait", 32'(n), 32'h0000_0002);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // read a register and compare with the expected word
  task automatic rd_chk(input string name, input logic [17:0] a,
                        input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(name, rdv, exp);
  endtask : rd_chk
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  // reset values and an unmapped address
  task automatic t_reset_map();
    rd_chk("csr_reset", ADDR_CTRL_STATUS, 32'h0000_0000);
    chk("mapped_err", {31'h0, errv}, 32'h0000_0000);
    rd_chk("cnt_reset", ADDR_COUNTER, 32'h0000_0000);
    rd_chk("irq_mask_reset", ADDR_IRQ_MASK, 32'h0000_0000);
    rd_chk("unmapped_rd", {16'hffd0, 2'b00}, 32'h0000_0000);
    chk("unmapped_err", {31'h0, errv}, 32'h0000_0001);
    apb(1'b1, {16'hffd0, 2'b00}, 32'h0000_00ff);
    chk("unmapped_wr_err", {31'h0, errv}, 32'h0000_0001);
  endtask : t_reset_map
  // counter writes only while the write enable is set
  task automatic t_counter_gate();
    apb(1'b1, ADDR_CTRL_STATUS, 32'h0000_0040);
    apb(1'b1, ADDR_COUNTER, 32'h0000_01a5);
    rd_chk("cnt_write_open", ADDR_COUNTER, 32'h0000_00a5);
    apb(1'b1, ADDR_CTRL_STATUS, 32'h0000_0000);
    apb(1'b1, ADDR_COUNTER, 32'h0000_0033);
    rd_chk("cnt_write_shut", ADDR_COUNTER, 32'h0000_00a5);
  endtask : t_counter_gate
  // walk the lock pairs through a table of writes and read-backs
  task automatic t_csr_locks();
    logic [7:0] wv [19];
    logic [7:0] ev [19];
    wv = '{8'h40, 8'hc0, 8'h80, 8'h00, 8'h00, 8'h04, 8'h10, 8'h30,
           8'h20, 8'h00, 8'h18, 8'h1c, 8'h10, 8'h11, 8'h13, 8'h12,
           8'h10, 8'h10, 8'h00};
    ev = '{8'h40, 8'hc0, 8'hc0, 8'h40, 8'h00, 8'h00, 8'h10, 8'h30,
           8'h30, 8'h10, 8'h18, 8'h18, 8'h10, 8'h11, 8'h13, 8'h13,
           8'h11, 8'h10, 8'h00};
    for (int i = 0; i < 19; i++) begin
      apb(1'b1, ADDR_CTRL_STATUS, {24'hff_ffff, wv[i]});
      rd_chk("csr_lock", ADDR_CTRL_STATUS, {24'h0, ev[i]});
    end
  endtask : t_csr_locks
  // blocked writes raise status bit1; mask gates the line; w1c clears
  task automatic t_irq();
    repeat (2) @(posedge i_clk);
    chk("irq_masked", {31'h0, irq}, 32'h0000_0000);
    apb(1'b1, ADDR_IRQ_MASK, 32'h0000_0002);
    repeat (2) @(posedge i_clk);
    chk("irq_raised", {31'h0, irq}, 32'h0000_0001);
    rd_chk("irq_status", ADDR_IRQ_STATUS, 32'h0000_0002);
    apb(1'b1, ADDR_IRQ_STATUS, 32'h0000_0002);
    repeat (2) @(posedge i_clk);
    chk("irq_cleared", {31'h0, irq}, 32'h0000_0000);
    rd_chk("irq_status_clr", ADDR_IRQ_STATUS, 32'h0000_0000);
  endtask : t_irq
  // load the program-pass count, run to overflow, then stop and write the erase-pass count with bit 6 still set
  task automatic t_overflow();
    int n;
    apb(1'b1, ADDR_IRQ_MASK, 32'h0000_0001);
    apb(1'b1, ADDR_CTRL_STATUS, 32'h0000_0040);
    apb(1'b1, ADDR_COUNTER, {24'h0, PROGRAM_PASS_COUNT});
    repeat (40) @(posedge i_clk);
    rd_chk("cnt_idle_off", ADDR_COUNTER, 32'h0000_00fb);
    apb(1'b1, ADDR_CTRL_STATUS, 32'h0000_0050);
    apb(1'b1, ADDR_CTRL_STATUS, 32'h0000_0054);
    n = 0;
    while (int_reset !== 1'b1 && n < 200) begin
      @(posedge i_clk);
      n++;
    end
    chk("ovf_time", {31'h0, n >= 5 * PRESC - 2 && n <= 5 * PRESC + 4},
        32'h0000_0001);
    @(posedge i_clk);
    chk("reset_pulse", {31'h0, int_reset}, 32'h0000_0000);
    rd_chk("cnt_wrapped", ADDR_COUNTER, 32'h0000_0000);
    chk("irq_ovf", {31'h0, irq}, 32'h0000_0001);
    rd_chk("csr_ovf", ADDR_CTRL_STATUS, 32'h0000_0055);
    apb(1'b1, ADDR_CTRL_STATUS, 32'h0000_0051);
    rd_chk("csr_off", ADDR_CTRL_STATUS, 32'h0000_0051);
    apb(1'b1, ADDR_COUNTER, {24'h0, ERASE_PASS_COUNT});
    rd_chk("cnt_erase", ADDR_COUNTER, 32'h0000_0000);
    apb(1'b1, ADDR_IRQ_STATUS, 32'h0000_0003);
    repeat (2) @(posedge i_clk);
    chk("irq_done", {31'h0, irq}, 32'h0000_0000);
  endtask : t_overflow
  // ----------------------------------------------------------------
  // verdict, sequence and watchdog
  // ----------------------------------------------------------------
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : test_done
  // main sequence
  initial begin
    repeat (3) @(posedge i_clk);
    i_reset_n <= 1'b1;
    t_reset_map();
    t_counter_gate();
    t_csr_locks();
    t_irq();
    t_overflow();
    test_done();
  end
  // cut a hang short well beyond the expected run length
  initial begin
    #50000;
    fail_count++;
    test_done();
  end
endmodule : test_watchdog_ctrl_write_protect
